// file: rtl/mps_consts.svh
// Constants of the motion parameter store: addresses, field slots, defaults and limits.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

// ----------------------------------------------------------------
// Table size and word layout
// ----------------------------------------------------------------
`define MPS_ENTRIES 64
`define MPS_FIELDS 8
`define MPS_PARAMS 4
`define MPS_F_POSITION 3'h0
`define MPS_F_SPEED 3'h1
`define MPS_F_MODE 3'h2
`define MPS_F_FUNC 3'h3
`define MPS_F_ACCEL 3'h4
`define MPS_F_DECEL 3'h5
`define MPS_F_SEQ 3'h6
`define MPS_F_DWELL 3'h7

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define MPS_PARAM_BASE 10'h200
`define MPS_P_TIMEOUT 2'h0
`define MPS_P_PARITY 2'h1
`define MPS_P_STOPBIT 2'h2
`define MPS_P_ACCUNIT 2'h3
`define MPS_CMD_ADDR 10'h210
`define MPS_STAT_ADDR 10'h211
`define MPS_CMD_COMMIT 0
`define MPS_CMD_RECONF 1
`define MPS_ST_REJ 0
`define MPS_ST_PEND 1
`define MPS_ST_BUSY 2

// ----------------------------------------------------------------
// Defaults and limits
// ----------------------------------------------------------------
`define MPS_DEF_SPEED 24'h0003e8
`define MPS_DEF_ACCEL 24'h007530
`define MPS_DEF_PARITY 24'h000001
`define MPS_MAX_SPEED 32'h000f4240
`define MPS_MAX_ACCEL 32'h000f4240
`define MPS_MAX_DWELL 32'h0000c350
`define MPS_MAX_FUNC 32'h00000002
`define MPS_MAX_PARITY 32'h00000002
`define MPS_MAX_BIT 32'h00000001
`define MPS_MAX_TIMEOUT 32'h00ffffff

`endif

// file: rtl/mps_pkg.sv
// Types shared by the motion parameter store and its users.
package mps_pkg;

  typedef enum logic [1:0] {SEQ_SINGLE, SEQ_LINKED, SEQ_LINKED2, SEQ_RSVD} seq_code_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSVD} parity_t;
  typedef enum {ST_LOAD, ST_WAIT, ST_APPLY, ST_IDLE, ST_COMMIT} state_t;

  typedef struct packed {
    logic signed [23:0] position;
    logic [19:0] speed;
    logic absolute_positioning;
    seq_code_t seq_code;
    logic [19:0] accel;
    logic [19:0] decel;
    logic seq_enable;
    logic [15:0] dwell;
  } entry_t;

  typedef struct packed {
    logic [23:0] comm_timeout;
    parity_t parity;
    logic two_stop_bits;
    logic accel_is_time;
  } cfg_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [23:0] wdata;
    logic we;
    logic re;
  } nv_req_t;

endpackage

// file: rtl/motion_parameter_store.sv
// Motion entry table and parameter store with persistent backing and timed update classes.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mps_consts.svh"

module motion_parameter_store #(
  parameter int ENTRIES = `MPS_ENTRIES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Motion side.
  input wire logic motion_active,
  input wire logic [5:0] entry_sel,
  output mps_pkg::entry_t entry_out,
  output mps_pkg::cfg_t cfg_out,
  output logic busy,
  // Persistent storage port, read data one cycle after the request.
  output mps_pkg::nv_req_t nv_req,
  input wire logic [23:0] nv_rdata
);
  import mps_pkg::*;

  localparam int EW = ENTRIES * `MPS_FIELDS;
  localparam int WORDS = EW + `MPS_PARAMS;
  localparam logic [9:0] LAST = 10'(WORDS - 1);

  // Storage indices of the settings words, which follow the entry table.
  // The settings sit above the entry table in the same storage array.
  localparam int I_TIMEOUT = EW + int'(`MPS_P_TIMEOUT);
  localparam int I_PARITY = EW + int'(`MPS_P_PARITY);
  localparam int I_STOPBIT = EW + int'(`MPS_P_STOPBIT);
  localparam int I_ACCUNIT = EW + int'(`MPS_P_ACCUNIT);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Reset value of one storage word; a constant for every constant index.
  function automatic logic [23:0] word_default(input int i);
    logic [23:0] v;
    v = 24'h000000;
    if (i < EW)
    begin
      if (3'(i) == `MPS_F_SPEED)
        v = `MPS_DEF_SPEED;
      else if (3'(i) == `MPS_F_ACCEL || 3'(i) == `MPS_F_DECEL)
        v = `MPS_DEF_ACCEL;
    end
    else if (2'(i - EW) == `MPS_P_PARITY)
      v = `MPS_DEF_PARITY;
    return v;
  endfunction

  // Range check of a host write; out-of-range values are refused whole.
  function automatic logic word_ok(input logic [9:0] a, input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    if (a < 10'(EW))
    begin
      case (a[2:0])
        `MPS_F_POSITION: ok = (v[31:23] == 9'h000) || (v[31:23] == 9'h1ff);
        `MPS_F_SPEED: ok = v <= `MPS_MAX_SPEED;
        `MPS_F_MODE: ok = v <= `MPS_MAX_BIT;
        `MPS_F_FUNC: ok = v <= `MPS_MAX_FUNC;
        `MPS_F_ACCEL: ok = v != 32'h0 && v <= `MPS_MAX_ACCEL;
        `MPS_F_DECEL: ok = v != 32'h0 && v <= `MPS_MAX_ACCEL;
        `MPS_F_SEQ: ok = v <= `MPS_MAX_BIT;
        default: ok = v <= `MPS_MAX_DWELL;
      endcase
    end
    else
    begin
      case (a[1:0])
        `MPS_P_TIMEOUT: ok = v <= `MPS_MAX_TIMEOUT;
        `MPS_P_PARITY: ok = v <= `MPS_MAX_PARITY;
        default: ok = v <= `MPS_MAX_BIT;
      endcase
    end
    return ok;
  endfunction

  // Host address to storage index, or WORDS when unmapped.
  function automatic int word_index(input logic [9:0] a);
    int idx;
    idx = WORDS;
    if (a < 10'(EW))
      idx = int'(a);
    else if (a >= `MPS_PARAM_BASE && a < `MPS_PARAM_BASE + 10'(`MPS_PARAMS))
      idx = EW + int'(a - `MPS_PARAM_BASE);
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [23:0] work_q [WORDS];
  logic [23:0] work_d [WORDS];
  logic [23:0] act_q [EW];
  logic [23:0] act_d [EW];
  state_t state_q, state_d;
  logic [9:0] cnt_q, cnt_d;
  logic ret_q, ret_d;
  logic [9:0] ret_idx_q, ret_idx_d;
  logic pend_q, pend_d;
  logic rej_q, rej_d;
  logic [31:0] rdata_d;
  entry_t entry_d;
  cfg_t cfg_d;
  nv_req_t nv_d;
  logic busy_d;
  // Decoded word index of the bus address and first word of the selected entry.
  int widx;
  int ebase;
  logic wr_ok;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Load, apply and commit sequencing plus host access; writes are refused outside ST_IDLE so a
  // commit always stores one consistent snapshot.
  always_comb
  begin
    work_d = work_q;
    act_d = act_q;
    state_d = state_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    rej_d = rej_q;
    cfg_d = cfg_out;
    nv_d = '0;
    widx = word_index(addr);
    wr_ok = wr && state_q == ST_IDLE && widx < WORDS && word_ok(addr, wdata);
    ret_d = nv_req.re;
    ret_idx_d = nv_req.addr;

    // Load data returns one cycle after each request.
    if (ret_q)
      work_d[ret_idx_q] = nv_rdata;

    case (state_q)
      ST_LOAD:
      begin
        nv_d.re = 1'b1;
        nv_d.addr = cnt_q;
        cnt_d = cnt_q + 10'h001;
        if (cnt_q == LAST)
          state_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (!nv_req.re && !ret_q)
          state_d = ST_APPLY;
      end
      ST_APPLY:
      begin
        // Power-up applies every class, including C and D.
        for (int i = 0; i < EW; i++)
          act_d[i] = work_q[i];
        cfg_d.comm_timeout = work_q[I_TIMEOUT];
        cfg_d.parity = parity_t'(work_q[I_PARITY][1:0]);
        cfg_d.two_stop_bits = work_q[I_STOPBIT][0];
        cfg_d.accel_is_time = work_q[I_ACCUNIT][0];
        pend_d = 1'b0;
        cnt_d = 10'h000;
        state_d = ST_IDLE;
      end
      ST_COMMIT:
      begin
        nv_d.we = 1'b1;
        nv_d.addr = cnt_q;
        nv_d.wdata = work_q[cnt_q];
        cnt_d = cnt_q + 10'h001;
        if (cnt_q == LAST)
          state_d = ST_IDLE;
      end
      default:
      begin
        // Class B: entries and the acceleration unit follow once motion stops.
        if (pend_q && !motion_active)
        begin
          for (int i = 0; i < EW; i++)
            act_d[i] = work_q[i];
          cfg_d.accel_is_time = work_q[I_ACCUNIT][0];
          pend_d = 1'b0;
        end
        if (wr && addr == `MPS_CMD_ADDR)
        begin
          if (wdata[`MPS_CMD_RECONF])
            cfg_d.parity = parity_t'(work_q[I_PARITY][1:0]);
          if (wdata[`MPS_CMD_COMMIT])
          begin
            cnt_d = 10'h000;
            state_d = ST_COMMIT;
          end
        end
      end
    endcase

    // Host writes land in the working copy; a timeout write also takes effect at once.
    if (wr_ok)
    begin
      work_d[widx] = wdata[23:0];
      if (widx < EW || widx == I_ACCUNIT)
        pend_d = 1'b1;
      if (widx == I_TIMEOUT)
        cfg_d.comm_timeout = wdata[23:0];
    end

    // A refusal seen in the clearing cycle still sets the flag.
    if (wr && addr == `MPS_STAT_ADDR && wdata[`MPS_ST_REJ])
      rej_d = 1'b0;
    if (wr && widx < WORDS && !wr_ok)
      rej_d = 1'b1;

    // Busy also covers the last storage write, so busy low means storage is quiet.
    busy_d = state_d != ST_IDLE || nv_d.we;

    // Selected entry as seen by the motion logic.
    // Field slots come from the layout constants so the bus map and this view cannot drift.
    ebase = int'(entry_sel) * `MPS_FIELDS;
    entry_d.position = act_q[ebase + int'(`MPS_F_POSITION)];
    entry_d.speed = act_q[ebase + int'(`MPS_F_SPEED)][19:0];
    entry_d.absolute_positioning = act_q[ebase + int'(`MPS_F_MODE)][0];
    entry_d.seq_code = seq_code_t'(act_q[ebase + int'(`MPS_F_FUNC)][1:0]);
    entry_d.accel = act_q[ebase + int'(`MPS_F_ACCEL)][19:0];
    entry_d.decel = act_q[ebase + int'(`MPS_F_DECEL)][19:0];
    entry_d.seq_enable = act_q[ebase + int'(`MPS_F_SEQ)][0];
    entry_d.dwell = act_q[ebase + int'(`MPS_F_DWELL)][15:0];

    // Reads show the working copy, the command register reads as zero.
    rdata_d = 32'h00000000;
    if (rd)
    begin
      if (widx < WORDS)
      begin
        if (widx < EW && addr[2:0] == `MPS_F_POSITION)
          rdata_d = {{8{work_q[widx][23]}}, work_q[widx]};
        else
          rdata_d = {8'h00, work_q[widx]};
      end
      else if (addr == `MPS_STAT_ADDR)
      begin
        rdata_d[`MPS_ST_REJ] = rej_q;
        rdata_d[`MPS_ST_PEND] = pend_q;
        rdata_d[`MPS_ST_BUSY] = busy;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Reset models loss of logic power: the working copy falls back to defaults and a load starts.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < WORDS; i++)
        work_q[i] <= word_default(i);
      for (int i = 0; i < EW; i++)
        act_q[i] <= word_default(i);
      state_q <= ST_LOAD;
      cnt_q <= 10'h000;
      ret_q <= 1'b0;
      ret_idx_q <= 10'h000;
      pend_q <= 1'b0;
      rej_q <= 1'b0;
      rdata <= 32'h00000000;
      entry_out <= '0;
      cfg_out <= '{comm_timeout: 24'h000000, parity: PAR_EVEN, two_stop_bits: 1'b0, accel_is_time: 1'b0};
      nv_req <= '0;
      busy <= 1'b1;
    end
    else
    begin
      work_q <= work_d;
      act_q <= act_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      ret_q <= ret_d;
      ret_idx_q <= ret_idx_d;
      pend_q <= pend_d;
      rej_q <= rej_d;
      rdata <= rdata_d;
      entry_out <= entry_d;
      cfg_out <= cfg_d;
      nv_req <= nv_d;
      busy <= busy_d;
    end
  end

endmodule

// file: test/mps_chk.sv
// Checker of the motion parameter store port behaviour.
`timescale 1ns/1ps
module mps_chk
  import mps_pkg::*;
#(
  parameter int ENTRIES = 64
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Motion and storage side.
  input wire logic motion_active,
  input wire logic [5:0] entry_sel,
  input wire mps_pkg::entry_t entry_out,
  input wire mps_pkg::cfg_t cfg_out,
  input wire logic busy,
  input wire mps_pkg::nv_req_t nv_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [2:0] reconf_q;
  logic [2:0] reconf_d;
  // Reconfigure may take a few cycles to land, so recent commands are kept.
  always_comb reconf_d = {reconf_q[1:0], wr && addr == 10'h210 && wdata[1]};
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      reconf_q <= 3'h0;
    else
      reconf_q <= reconf_d;
  sequence commit_cmd;
    wr && addr == 10'h210 && wdata[0] && !busy;
  endsequence
  sequence store_first;
    busy ##1 (nv_req.we && nv_req.addr == 10'h000);
  endsequence
  commit_walk_a: assert property (commit_cmd |=> store_first)
    else $error("commit did not store word zero");
  store_quiet_a: assert property (wr && !busy && addr != 10'h210 |=> !nv_req.we)
    else $error("host write reached storage");
  store_busy_a: assert property (nv_req.we |-> busy)
    else $error("storage write while idle");
  timeout_now_a: assert property (wr && !busy && addr == 10'h200 && wdata[31:24] == 8'h0 |=>
    32'(cfg_out.comm_timeout) == $past(wdata)) else $error("timeout not applied at once");
  unit_hold_a: assert property (motion_active && !busy |=> $stable(cfg_out.accel_is_time))
    else $error("unit changed in motion");
  stop_fixed_a: assert property (!busy |=> $stable(cfg_out.two_stop_bits))
    else $error("stop bits changed after power-up");
  parity_hold_a: assert property ($changed(cfg_out.parity) |-> busy || $past(busy) || |reconf_q)
    else $error("parity changed without reconfigure");
  entry_hold_a: assert property (motion_active && $past(motion_active) && $stable(entry_sel) && !busy
    |=> $stable(entry_out)) else $error("entry changed in motion");
endmodule
bind motion_parameter_store mps_chk #(.ENTRIES(ENTRIES)) mps_chk_i (.clk(clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .motion_active(motion_active), .entry_sel(entry_sel), .entry_out(entry_out),
  .cfg_out(cfg_out), .busy(busy), .nv_req(nv_req));

// file: test/nv_store_model.sv
// Persistent storage model answering load and commit requests.
`timescale 1ns/1ps
module nv_store_model
  import mps_pkg::*;
(
  // Clock and request.
  input wire logic clk,
  input wire mps_pkg::nv_req_t nv_req,
  // Read data.
  output logic [23:0] nv_rdata
);
  logic [23:0] mem [516];
  // Words start at the defaults, with a few changed so a load is visible.
  initial
  begin
    for (int i = 0; i < 516; i++)
      mem[i] = (i % 8 == 1) ? 24'h0003e8 : (i % 8 == 4 || i % 8 == 5) ? 24'h007530 : 24'h0;
    mem[0] = 24'h000123;
    mem[513] = 24'h000002;
    mem[514] = 24'h000001;
    nv_rdata = 24'h0;
  end
  // Data stands one cycle after a read; otherwise the lines toggle so stale data is never mistaken.
  always @(posedge clk)
  begin
    if (nv_req.we)
      mem[nv_req.addr] <= nv_req.wdata;
    nv_rdata <= nv_req.re ? mem[nv_req.addr] : ~nv_rdata;
  end
endmodule

// file: test/tb_motion_parameter_store.sv
// Testbench of the motion parameter store with a persistent storage model.
`timescale 1ns/1ps
module tb_motion_parameter_store;
  import mps_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic [9:0] addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic motion_active = 1'b0;
  logic [5:0] entry_sel = 6'h0;
  logic [31:0] rdata;
  entry_t entry_out;
  cfg_t cfg_out;
  logic busy;
  nv_req_t nv_req;
  logic [23:0] nv_rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  motion_parameter_store motion_parameter_store_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .motion_active(motion_active), .entry_sel(entry_sel),
    .entry_out(entry_out), .cfg_out(cfg_out), .busy(busy), .nv_req(nv_req), .nv_rdata(nv_rdata));
  nv_store_model nv_store_model_i (.clk(clk), .nv_req(nv_req), .nv_rdata(nv_rdata));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [9:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask
  // Busy is awaited under a bound so a stuck store ends the run.
  task automatic settle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      tick(1);
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // Reset falls on an edge so the asynchronous reset sees a real falling edge every time.
  task automatic power_up();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    tick(1);
    settle();
  endtask
  task automatic show(input logic [5:0] n);
    @(posedge clk);
    entry_sel <= n;
    tick(2);
  endtask
  task automatic motion(input logic v);
    @(posedge clk);
    motion_active <= v;
  endtask
  initial
  begin
    power_up();
    check("parity", 32'(cfg_out.parity), 32'(PAR_ODD));
    show(6'd5);
    check("speed", 32'(entry_out.speed), 32'd1000);
    check("accel", 32'(entry_out.accel), 32'd30000);
    check("unit", 32'(cfg_out.accel_is_time), 32'h0);
    show(6'd0);
    check("position", 32'(entry_out.position), 32'h123);
    get(10'h1f8, 32'h0, "last position");
    put(10'h1f8, 32'hffffffff);
    get(10'h1f8, 32'hffffffff, "negative position");
    put(10'h004, 32'h0);
    get(10'h004, 32'h7530, "accel floor");
    put(10'h00f, 32'd50001);
    get(10'h00f, 32'h0, "dwell ceiling");
    put(10'h00f, 32'd50000);
    get(10'h00f, 32'd50000, "dwell max");
    put(10'h00a, 32'h1);
    put(10'h00b, 32'h2);
    put(10'h00e, 32'h1);
    put(10'h00b, 32'h3);
    show(6'h01);
    check("dwell", 32'(entry_out.dwell), 32'd50000);
    check("absolute", 32'(entry_out.absolute_positioning), 32'h1);
    check("sequence code", 32'(entry_out.seq_code), 32'(SEQ_LINKED2));
    check("sequence enable", 32'(entry_out.seq_enable), 32'h1);
    check("decel", 32'(entry_out.decel), 32'd30000);
    show(6'h00);
    get(10'h211, 32'h1, "refusal flag");
    put(10'h211, 32'h1);
    get(10'h211, 32'h0, "refusal cleared");
    motion(1'b1);
    put(10'h000, 32'h5);
    put(10'h203, 32'h1);
    tick(4);
    check("held position", 32'(entry_out.position), 32'h123);
    check("held unit", 32'(cfg_out.accel_is_time), 32'h0);
    get(10'h000, 32'h5, "working position");
    get(10'h211, 32'h2, "pending flag");
    motion(1'b0);
    tick(4);
    check("applied position", 32'(entry_out.position), 32'h5);
    check("applied unit", 32'(cfg_out.accel_is_time), 32'h1);
    put(10'h200, 32'h1234);
    tick(1);
    check("timeout", 32'(cfg_out.comm_timeout), 32'h1234);
    put(10'h201, 32'h0);
    put(10'h202, 32'h0);
    tick(4);
    check("parity held", 32'(cfg_out.parity), 32'(PAR_ODD));
    put(10'h210, 32'h2);
    tick(4);
    check("parity reconf", 32'(cfg_out.parity), 32'(PAR_NONE));
    check("stop held", 32'(cfg_out.two_stop_bits), 32'h1);
    check("stored position", 32'(nv_store_model_i.mem[0]), 32'h123);
    put(10'h210, 32'h1);
    get(10'h211, 32'h4, "busy flag");
    settle();
    check("commit position", 32'(nv_store_model_i.mem[0]), 32'h5);
    check("commit timeout", 32'(nv_store_model_i.mem[512]), 32'h1234);
    get(10'h300, 32'h0, "unmapped");
    put(10'h200, 32'h77);
    power_up();
    get(10'h200, 32'h1234, "lost timeout");
    check("stop loaded", 32'(cfg_out.two_stop_bits), 32'h0);
    check("entry loaded", 32'(entry_out.position), 32'h5);
    complete_run();
  end
endmodule
